// ---- verilog/cbw_seq.sv ----
// Bus-master transaction sequencer: strobes, wait cycles, interlocked access.
// Assumes slaves answer with async ack or sync ready; one clock, one edge per state.
`timescale 1ns/1ps
`include "cbw_regs.svh"
module cbw_seq (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    input wire cbw_pkg::cbw_req_type i_req,
    input wire logic i_intlk_wr_go,
    input wire logic [31:0] i_intlk_wdata,
    input wire logic i_async_xfer_ack_n,
    input wire logic i_sync_ready_n,
    input wire cbw_pkg::cbw_exc_type i_exc,
    input wire logic [31:0] i_data_in,
    input wire logic i_bus_request,
    output logic o_req_ready,
    output logic o_addr_strobe_n,
    output logic o_data_strobe_n,
    output logic o_rd_wr,
    output logic [31:0] o_addr,
    output logic [31:0] o_data_out,
    output logic o_data_oe,
    output logic [3:0] o_access_status_code,
    output logic o_cycle_initiate,
    output logic o_data_ready_out_n,
    output logic [31:0] o_rdata,
    output logic o_done,
    output logic o_fault,
    output logic o_intlk_pending,
    output logic o_bus_grant
);
    // One clock edge per clock state; two states make one bus cycle.
    cbw_pkg::cbw_phase_type ph_r, ph_nxt;
    logic ack_n_s, rdy_n_s;
    cbw_pkg::cbw_exc_type exc_s;
    logic write_r, write_nxt, intlk_r, intlk_nxt, lock_r, lock_nxt;
    logic as_r, as_nxt, ds_r, ds_nxt, rw_r, rw_nxt, oe_r, oe_nxt;
    logic cyi_r, cyi_nxt, data_ready_out_n_r, data_ready_out_n_nxt, done_r, done_nxt, flt_r, flt_nxt;
    logic rdy_r, rdy_nxt, grant_r, grant_nxt;
    logic [2:0] cyi_cnt_r, cyi_cnt_nxt;
    logic [3:0] sas_r, sas_nxt;
    logic [31:0] addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
    logic acked_r, acked_nxt;
    logic exc_any;
    logic [31:0] din_s;

    cbw_sync #(.WIDTH(5), .RST_VAL(5'h1F)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_async_xfer_ack_n, i_sync_ready_n, i_exc}),
        .o_sync({ack_n_s, rdy_n_s, exc_s})
    );

    // Read data bus also crosses in from the pins
    cbw_sync #(.WIDTH(32), .RST_VAL(32'h0000_0000)) u_sync_data (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async(i_data_in),
        .o_sync(din_s)
    );

    function automatic logic any_exc(input cbw_pkg::cbw_exc_type e);
        any_exc = !e.fault_n || !e.retry_n || !e.relinquish_retry_req_n;
    endfunction

    assign exc_any = any_exc(exc_s);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ph_nxt = ph_r;
        write_nxt = write_r;
        intlk_nxt = intlk_r;
        lock_nxt = lock_r;
        as_nxt = as_r;
        ds_nxt = ds_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        sas_nxt = sas_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        acked_nxt = acked_r;
        cyi_cnt_nxt = (cyi_cnt_r != 3'h0) ? cyi_cnt_r - 3'h1 : 3'h0;
        cyi_nxt = (cyi_cnt_nxt != 3'h0);
        data_ready_out_n_nxt = 1'b1;
        done_nxt = 1'b0;
        flt_nxt = 1'b0;
        rdy_nxt = 1'b0;
        grant_nxt = i_bus_request && (ph_r == cbw_pkg::CBW_IDLE) && !lock_r;
        case (ph_r)
            cbw_pkg::CBW_IDLE: begin
                rdy_nxt = !lock_r;
                if (lock_r && i_intlk_wr_go) begin
                    // Second half of an interlock: same address and code
                    write_nxt = 1'b1;
                    wd_nxt = i_intlk_wdata;
                    sas_nxt = `CBW_SAS_RD_INTLK;
                    rw_nxt = 1'b0;
                    ph_nxt = cbw_pkg::CBW_S0;
                    rdy_nxt = 1'b0;
                    grant_nxt = 1'b0;
                end else if (!lock_r && i_req_valid && !i_bus_request) begin
                    write_nxt = i_req.write && !i_req.interlock;
                    intlk_nxt = i_req.interlock;
                    addr_nxt = i_req.addr;
                    wd_nxt = i_req.wdata;
                    if (i_req.interlock)
                        sas_nxt = `CBW_SAS_RD_INTLK;
                    else if (i_req.write)
                        sas_nxt = `CBW_SAS_WRITE;
                    else
                        sas_nxt = `CBW_SAS_READ;
                    rw_nxt = !(i_req.write && !i_req.interlock);
                    ph_nxt = cbw_pkg::CBW_S0;
                    rdy_nxt = 1'b0;
                end
            end
            cbw_pkg::CBW_S0: begin
                as_nxt = 1'b0;
                ds_nxt = write_r;
                cyi_cnt_nxt = `CBW_CYCLE_INITIATE_STATES;
                cyi_nxt = 1'b1;
                acked_nxt = 1'b0;
                ph_nxt = cbw_pkg::CBW_S1;
            end
            cbw_pkg::CBW_S1: begin
                oe_nxt = write_r;
                ph_nxt = cbw_pkg::CBW_S2;
            end
            cbw_pkg::CBW_S2: begin
                ds_nxt = 1'b0;
                acked_nxt = !ack_n_s;
                ph_nxt = cbw_pkg::CBW_S3;
            end
            cbw_pkg::CBW_S3: begin
                // Ack taken at state two arrives here through the synchroniser
                if (acked_r || !ack_n_s || !rdy_n_s || exc_any)
                    ph_nxt = cbw_pkg::CBW_S4;
                else
                    ph_nxt = cbw_pkg::CBW_WA;
            end
            cbw_pkg::CBW_WA: begin
                acked_nxt = !ack_n_s;
                ph_nxt = cbw_pkg::CBW_WB;
            end
            cbw_pkg::CBW_WB: begin
                if (acked_r || !rdy_n_s || exc_any)
                    ph_nxt = cbw_pkg::CBW_S4;
                else
                    ph_nxt = cbw_pkg::CBW_WA;
            end
            cbw_pkg::CBW_S4: begin
                as_nxt = 1'b1;
                ds_nxt = 1'b1;
                if (!write_r)
                    rd_nxt = din_s;
                data_ready_out_n_nxt = exc_any;
                flt_nxt = !exc_s.fault_n;
                sas_nxt = `CBW_SAS_NOP;
                ph_nxt = cbw_pkg::CBW_S5;
                if (intlk_r && !write_r)
                    lock_nxt = exc_s.fault_n;
                else if (intlk_r)
                    lock_nxt = 1'b0;
            end
            cbw_pkg::CBW_S5: begin
                oe_nxt = 1'b0;
                ph_nxt = cbw_pkg::CBW_REL;
            end
            cbw_pkg::CBW_REL: begin
                done_nxt = 1'b1;
                if (!lock_r)
                    intlk_nxt = 1'b0;
                ph_nxt = cbw_pkg::CBW_IDLE;
            end
            default: ph_nxt = cbw_pkg::CBW_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ph_r <= cbw_pkg::CBW_IDLE;
            write_r <= 1'b0;
            intlk_r <= 1'b0;
            lock_r <= 1'b0;
            as_r <= 1'b1;
            ds_r <= 1'b1;
            rw_r <= 1'b1;
            oe_r <= 1'b0;
            sas_r <= `CBW_SAS_NOP;
            addr_r <= 32'h0000_0000;
            wd_r <= 32'h0000_0000;
            rd_r <= 32'h0000_0000;
            acked_r <= 1'b0;
            cyi_cnt_r <= 3'h0;
            cyi_r <= 1'b0;
            data_ready_out_n_r <= 1'b1;
            done_r <= 1'b0;
            flt_r <= 1'b0;
            rdy_r <= 1'b0;
            grant_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            write_r <= write_nxt;
            intlk_r <= intlk_nxt;
            lock_r <= lock_nxt;
            as_r <= as_nxt;
            ds_r <= ds_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            sas_r <= sas_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            acked_r <= acked_nxt;
            cyi_cnt_r <= cyi_cnt_nxt;
            cyi_r <= cyi_nxt;
            data_ready_out_n_r <= data_ready_out_n_nxt;
            done_r <= done_nxt;
            flt_r <= flt_nxt;
            rdy_r <= rdy_nxt;
            grant_r <= grant_nxt;
        end
    end

    assign o_req_ready = rdy_r;
    assign o_addr_strobe_n = as_r;
    assign o_data_strobe_n = ds_r;
    assign o_rd_wr = rw_r;
    assign o_addr = addr_r;
    assign o_data_out = wd_r;
    assign o_data_oe = oe_r;
    assign o_access_status_code = sas_r;
    assign o_cycle_initiate = cyi_r;
    assign o_data_ready_out_n = data_ready_out_n_r;
    assign o_rdata = rd_r;
    assign o_done = done_r;
    assign o_fault = flt_r;
    assign o_intlk_pending = lock_r;
    assign o_bus_grant = grant_r;

    ////////////////////////////////////////////////////////////////////////
    a_write_rw_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (write_r && ph_r != cbw_pkg::CBW_IDLE && ph_r != cbw_pkg::CBW_S0) |-> !o_rd_wr)
        else $error("direction high during write");
    a_read_rw_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!write_r && !o_addr_strobe_n) |-> o_rd_wr)
        else $error("direction low during read");
    a_write_ds_lag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ($fell(o_addr_strobe_n) && write_r) |-> o_data_strobe_n ##1 o_data_strobe_n
        ##1 !o_data_strobe_n)
        else $error("write data strobe timing");
    a_read_ds_same: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!write_r) |-> (o_data_strobe_n == o_addr_strobe_n))
        else $error("read strobes differ");
    a_zero_wait_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S3 && (acked_r || !ack_n_s || !rdy_n_s || exc_any))
        |=> ph_r == cbw_pkg::CBW_S4 ##1 $rose(o_addr_strobe_n) ##2 o_done)
        else $error("zero wait length wrong");
    a_cycle_init_two: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(o_cycle_initiate) |-> o_cycle_initiate [*4] ##1 !o_cycle_initiate)
        else $error("cycle initiate width");
    a_wait_on_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S3 && !acked_r && ack_n_s && rdy_n_s && !exc_any)
        |=> ph_r == cbw_pkg::CBW_WA)
        else $error("missing wait cycle");
    a_wait_ready_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_WB && !rdy_n_s) |=> ph_r == cbw_pkg::CBW_S4)
        else $error("ready ignored in wait");
    a_wait_ack_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_WA && !ack_n_s) |=> ##1 ph_r == cbw_pkg::CBW_S4)
        else $error("ack ignored in wait");
    a_write_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S0 && write_r && !intlk_r) |-> sas_r == `CBW_SAS_WRITE)
        else $error("write status code");
    a_intlk_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S0 && intlk_r) |-> sas_r == `CBW_SAS_RD_INTLK)
        else $error("interlock status code");
    a_data_driven: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (write_r && !o_data_strobe_n) |-> o_data_oe)
        else $error("write data not driven");
    a_fault_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S4 && intlk_r && !write_r && !exc_s.fault_n) |=> !lock_r)
        else $error("interlock kept after fault");
    a_data_ready_out_n_exc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (ph_r == cbw_pkg::CBW_S4 && exc_any) |=> o_data_ready_out_n)
        else $error("data ready on exception");
    a_no_grant_lock: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        lock_r |=> !o_bus_grant)
        else $error("grant during interlock");
    c_wait_read: cover property (@(posedge i_clk) ph_r == cbw_pkg::CBW_WB && !write_r);
    c_wait_write: cover property (@(posedge i_clk) ph_r == cbw_pkg::CBW_WB && write_r);
    c_intlk_full: cover property (@(posedge i_clk) $fell(lock_r) && write_r);
    c_exc_end: cover property (@(posedge i_clk) ph_r == cbw_pkg::CBW_S4 && exc_any);
endmodule // cbw_seq

// ---- verilog/cbw_regs.svh ----
// Constants for the bus transaction sequencer: codes and timing counts.
// Assumes one 40 MHz clock; a clock state is one half of a bus cycle.
`ifndef CBW_REGS_SVH
`define CBW_REGS_SVH
`define CBW_SAS_WRITE 4'hA
`define CBW_SAS_RD_INTLK 4'h7
`define CBW_SAS_NOP 4'hF
`define CBW_SAS_READ 4'h4
`define CBW_CYCLE_INITIATE_STATES 3'h4
`define CBW_CLK_NS 25
`endif

// ---- verilog/cbw_pkg.sv ----
// Types for the bus transaction sequencer.
// Assumes the constant header is included by the users of these types.
package cbw_pkg;
    // Clock-state phases, Gray coded along the usual path except the CBW_REL to CBW_IDLE return
    typedef enum logic [3:0] {
        CBW_IDLE = 4'h0,
        CBW_S0 = 4'h1,
        CBW_S1 = 4'h3,
        CBW_S2 = 4'h2,
        CBW_S3 = 4'h6,
        CBW_WA = 4'h7,
        CBW_WB = 4'h5,
        CBW_S4 = 4'h4,
        CBW_S5 = 4'hC,
        CBW_REL = 4'hD
    } cbw_phase_type;

    typedef struct packed {
        logic write;
        logic interlock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cbw_req_type;

    typedef struct packed {
        logic fault_n;
        logic retry_n;
        logic relinquish_retry_req_n;
    } cbw_exc_type;
endpackage

// ---- verilog/cbw_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes inputs arrive from outside the clock domain.
`timescale 1ns/1ps
module cbw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule // cbw_sync

// ---- verification/cbw_slave_model.sv ----
// Slave model: answers each strobe with ack or ready after a set delay.
// Assumes active-low strobes and one shared clock.
`timescale 1ns/1ps
module cbw_slave_model (
    input wire logic i_clk,
    input wire logic i_as_n,
    input wire logic i_ds_n,
    input wire logic i_rd_wr,
    input wire logic [31:0] i_wdata,
    input wire logic i_use_ready,
    input wire logic [3:0] i_delay,
    input wire logic i_fault,
    input wire logic i_retry,
    input wire logic [31:0] i_rdata,
    output logic o_ack_n,
    output logic o_ready_n,
    output cbw_pkg::cbw_exc_type o_exc,
    output logic [31:0] o_data,
    output logic [31:0] o_wcap
);
    logic [3:0] cnt_r = 4'h0;
    logic [31:0] last_r = 32'h0;
    logic resp;
    initial o_wcap = 32'h0;
    always @(posedge i_clk) begin
        cnt_r <= i_as_n ? 4'h0 : ((cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1);
        if (!i_as_n && i_rd_wr) last_r <= i_rdata;
    end
    // Answer only while selected; released lines go high
    assign resp = !i_as_n && (cnt_r >= i_delay);
    assign o_ack_n = !(resp && !i_use_ready);
    assign o_ready_n = !(resp && i_use_ready);
    assign o_exc = '{fault_n: !(resp && i_fault), retry_n: !(resp && i_retry),
                     relinquish_retry_req_n: 1'b1};
    // Unselected bus shows the inverse of the last value
    assign o_data = (!i_as_n && i_rd_wr) ? i_rdata : ~last_r;
    always @(negedge i_ds_n) begin
        if (!i_rd_wr) o_wcap <= i_wdata;
    end
endmodule // cbw_slave_model

// ---- verification/test_cpu_bus_wait_and_interlock.sv ----
// Self-checking bench for the bus sequencer with a slave model.
// Assumes a 40 MHz clock and inputs driven 2 ns after the rising edge.
`timescale 1ns/1ps
`include "cbw_regs.svh"
module test_cpu_bus_wait_and_interlock;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_req_valid = 1'b0;
    cbw_pkg::cbw_req_type i_req = '0;
    logic i_intlk_wr_go = 1'b0;
    logic [31:0] i_intlk_wdata = 32'h0;
    logic i_bus_request = 1'b0;
    logic use_rdy = 1'b0, s_fault = 1'b0, s_retry = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] s_rdata = 32'h0;
    logic ack_n, rdy_n, as_n, ds_n, rd_wr, oe, cyi, data_ready_out_n_n, done, fault, pend, grant, req_rdy;
    cbw_pkg::cbw_exc_type exc;
    logic [31:0] din, wcap, addr, dout, rdata, exp_wd, addr_seen;
    logic [3:0] sas, sas_seen;
    logic mon_on = 1'b0, exp_rw, rw_bad, data_bad, data_ready_out_n_seen, fault_seen;
    int err_count = 0, cmp_count = 0, n, as_at, ds_at, cyi_cnt, done_at;

    always #12.5 i_clk = ~i_clk;

    cbw_seq i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_intlk_wr_go(i_intlk_wr_go), .i_intlk_wdata(i_intlk_wdata),
        .i_async_xfer_ack_n(ack_n), .i_sync_ready_n(rdy_n), .i_exc(exc), .i_data_in(din),
        .i_bus_request(i_bus_request), .o_req_ready(req_rdy), .o_addr_strobe_n(as_n),
        .o_data_strobe_n(ds_n), .o_rd_wr(rd_wr), .o_addr(addr), .o_data_out(dout),
        .o_data_oe(oe), .o_access_status_code(sas), .o_cycle_initiate(cyi),
        .o_data_ready_out_n(data_ready_out_n_n), .o_rdata(rdata), .o_done(done), .o_fault(fault),
        .o_intlk_pending(pend), .o_bus_grant(grant));
    cbw_slave_model i_slave (.i_clk(i_clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_rd_wr(rd_wr),
        .i_wdata(dout), .i_use_ready(use_rdy), .i_delay(dly), .i_fault(s_fault),
        .i_retry(s_retry), .i_rdata(s_rdata), .o_ack_n(ack_n), .o_ready_n(rdy_n),
        .o_exc(exc), .o_data(din), .o_wcap(wcap));

    ////////////////////////////////////////////////////////////////////////////////
    // Transaction monitor, sampled mid-cycle
    always @(negedge i_clk) begin
        if (mon_on) begin
            if (!as_n && as_at < 0) begin
                as_at = n;
                sas_seen = sas;
                addr_seen = addr;
            end
            if (!ds_n && ds_at < 0) ds_at = n;
            if (!as_n && rd_wr !== exp_rw) rw_bad = 1'b1;
            if (!ds_n && !exp_rw && (dout !== exp_wd || oe !== 1'b1)) data_bad = 1'b1;
            if (cyi === 1'b1) cyi_cnt++;
            if (data_ready_out_n_n === 1'b0) data_ready_out_n_seen = 1'b1;
            if (fault === 1'b1) fault_seen = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tmo(input string what);
        err_count++;
        $display("mismatch %s expected done seen timeout", what);
        wrap_up();
    endtask

    task automatic mon_clear(input logic rw, input logic [31:0] wd);
        n = 0;
        as_at = -1;
        ds_at = -1;
        cyi_cnt = 0;
        rw_bad = 1'b0;
        data_bad = 1'b0;
        data_ready_out_n_seen = 1'b0;
        fault_seen = 1'b0;
        exp_rw = rw;
        exp_wd = wd;
        mon_on = 1'b1;
    endtask

    task automatic do_reset();
        i_sys_rst = 1'b1;
        repeat (20) @(posedge i_clk);
        chk("reset strobes", 32'h3, {as_n, ds_n});
        chk("reset rw sas oe data_ready_out_n", {1'b1, 4'hF, 1'b0, 1'b1}, {rd_wr, sas, oe, data_ready_out_n_n});
        #2 i_sys_rst = 1'b0;
    endtask

    task automatic start_req(input logic wr, input logic il, input logic [31:0] a, wd);
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge i_clk);
            #2;
            if (req_rdy === 1'b1) break;
        end
        if (k == 40) tmo("take");
        i_req = '{write: wr, interlock: il, addr: a, wdata: wd};
        i_req_valid = 1'b1;
        @(posedge i_clk);
        mon_clear(!wr || il, wd);
        #2 i_req_valid = 1'b0;
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 80; k++) begin
            @(posedge i_clk);
            n = n + 1;
            #3;
            if (done === 1'b1) break;
        end
        if (k == 80) tmo("done");
        done_at = n;
        @(posedge i_clk);
        mon_on = 1'b0;
        #2;
    endtask

    task automatic check_xfer(input logic [3:0] code, input logic [31:0] a, input logic zero);
        chk("code", code, sas_seen);
        chk("address", a, addr_seen);
        chk("direction held", 32'h0, rw_bad);
        chk("as start", 32'h1, as_at);
        chk("ds start", exp_rw ? 32'h1 : 32'h3, ds_at);
        chk("cycle initiate", `CBW_CYCLE_INITIATE_STATES, cyi_cnt);
        chk("data ready", 32'h1, data_ready_out_n_seen);
        if (zero) chk("done edge", 32'h7, done_at);
        else chk("waited", 32'hB, done_at);
        if (exp_rw) chk("read data", s_rdata, rdata);
        else chk("write data held", 32'h0, data_bad);
        if (!exp_rw) chk("slave capture", exp_wd, wcap);
    endtask

    task automatic plain(input logic wr, input int i);
        use_rdy = i[0];
        dly = i[1] ? 4'h3 : 4'h0;
        s_rdata = 32'h5A00_0000 + i;
        start_req(wr, 1'b0, 32'h0000_0100 + i * 16, 32'hA5A5_0000 + i);
        wait_done();
        check_xfer(wr ? `CBW_SAS_WRITE : `CBW_SAS_READ, 32'h0000_0100 + i * 16, !i[1]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reads();
        for (int i = 0; i < 4; i++) plain(1'b0, i);
    endtask

    task automatic t_writes();
        for (int i = 0; i < 4; i++) plain(1'b1, i);
    endtask

    task automatic t_interlock();
        plain(1'b0, 0);
        start_req(1'b0, 1'b1, 32'h0000_0A40, 32'h0);
        wait_done();
        check_xfer(`CBW_SAS_RD_INTLK, 32'h0000_0A40, 1'b1);
        i_req = '{write: 1'b0, interlock: 1'b0, addr: 32'h0, wdata: 32'h0};
        i_req_valid = 1'b1;
        i_bus_request = 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            #2 chk("grant and ready", 32'h0, {grant, req_rdy});
        end
        chk("pending", 32'h1, pend);
        i_req_valid = 1'b0;
        i_bus_request = 1'b0;
        i_intlk_wdata = 32'hC0DE_0001;
        i_intlk_wr_go = 1'b1;
        @(posedge i_clk);
        mon_clear(1'b0, 32'hC0DE_0001);
        #2 i_intlk_wr_go = 1'b0;
        wait_done();
        check_xfer(`CBW_SAS_RD_INTLK, 32'h0000_0A40, 1'b1);
        chk("pending after", 32'h0, pend);
    endtask

    task automatic t_intlk_fault();
        s_fault = 1'b1;
        start_req(1'b0, 1'b1, 32'h0000_0B80, 32'h0);
        wait_done();
        s_fault = 1'b0;
        chk("fault", 32'h1, fault_seen);
        chk("no data ready", 32'h0, data_ready_out_n_seen);
        i_intlk_wr_go = 1'b1;
        mon_clear(1'b0, 32'h0);
        repeat (20) @(posedge i_clk);
        #2 i_intlk_wr_go = 1'b0;
        chk("write skipped", 32'hFFFF_FFFF, as_at);
        chk("pending cleared", 32'h0, pend);
        i_bus_request = 1'b1;
        @(posedge i_clk);
        #2 chk("grant free", 32'h1, grant);
        i_bus_request = 1'b0;
    endtask

    task automatic t_retry();
        s_retry = 1'b1;
        start_req(1'b0, 1'b0, 32'h0000_0C00, 32'h0);
        repeat (30) @(posedge i_clk);
        #2 s_retry = 1'b0;
        chk("retry data ready", 32'h0, data_ready_out_n_seen);
        do_reset();
    endtask

    initial begin
        do_reset();
        t_reads();
        t_writes();
        t_interlock();
        t_intlk_fault();
        t_retry();
        plain(1'b0, 3);
        wrap_up();
    end
endmodule // test_cpu_bus_wait_and_interlock
